// file: verilog/oms_regs.svh
// constants of the operating-mode supervisor: offsets, fields, resets, timing
// assumes inclusion by bare name from the supervisor module only
// Function
// R1: normal flag only when wake, no fail-safe, no fault
// R2: wake is pin or either input activity
// R3: fail-safe from supply fail or watchdog timeout
// R4: fault is OR of protection faults, gated overvoltage
// R5: priority sleep, then fault, then fail-safe
// R6: direct control follows input with default settings
// R7: target is direct input or gated on bit
// R8: duty comes from pulse width bits 7..0
// R9: rising wake pin or input enters normal
// R10: host toggles watchdog bit within 310 ms
// R11: watchdog starts on wake rise, watches first bit
// R12: watchdog runs only with supply, enable, wake
// R13: input idle over 250 ms drops activity
// R14: sleep turns off channels, serial, holds defaults
// R15: sleep after power-up before any wake
// R16: wake pin low or fail-safe: direct control only
// R17: host keeps wake high for slow inputs
// R18: fail-safe entry drives indicator low, resets registers
// R19: exit fail-safe by toggle word then second word
// R20: exit releases indicator, resets registers again
// R21: serial words 16 bits, msb first, falling edge
// R22: wake resets registers, ready 50 us later
// R23: timeouts count internal oscillator ticks
`ifndef OMS_REGS_SVH
`define OMS_REGS_SVH

`define OMS_REG_CFG 4'h0
`define OMS_REG_PW0 4'h1
`define OMS_REG_PW1 4'h2
`define OMS_REG_STATUS 4'h3

`define OMS_CFG_MSB 7
`define OMS_PW_MSB 8
`define OMS_CFG_RESET 8'h04
`define OMS_PW_RESET 9'h000
`define OMS_STAT_PAD 4'h0

`define OMS_CLK_NS 10
`define OMS_TICK_NS 1000
`define OMS_WD_TIMEOUT_MS 310
`define OMS_ACT_TIMEOUT_MS 250
`define OMS_READY_US 50
`define OMS_PWM_DIV 16

`endif

// file: verilog/oms_pkg.sv
// types of the operating-mode supervisor
// assumes nothing; used by the supervisor module and the bench
package oms_pkg;

	typedef enum logic [1:0] {
		OMS_SLEEP = 2'b00,
		OMS_NORMAL = 2'b01,
		OMS_FAILSAFE = 2'b10,
		OMS_FAULT = 2'b11
	} oms_mode_t;

	typedef struct packed {
		logic sclk;
		logic csn;
		logic si;
	} oms_link_t;

	typedef struct packed {
		logic [1:0] overcurrent;
		logic [1:0] overtemperature;
		logic [1:0] short_circuit;
		logic undervoltage;
		logic overvoltage;
	} oms_faults_t;

	typedef struct packed {
		logic parallel_mode_flag;
		logic [1:0] direct_input_disable;
		logic [1:0] pwm_enable;
		logic overvoltage_fault_select;
		logic logic_supply_fail_enable;
		logic watchdog_disable;
	} oms_cfg_t;

	typedef struct packed {
		logic channel_on_bit;
		logic [7:0] duty;
	} oms_pw_t;

	typedef struct packed {
		oms_link_t link_s1;
		oms_link_t link_s2;
		logic sclk_prev;
		logic wake_s1;
		logic wake_s2;
		logic wake_prev;
		logic [1:0] din_s1;
		logic [1:0] din_s2;
		logic [1:0] din_prev;
		logic lsf_s1;
		logic lsf_s2;
		oms_faults_t flt_s1;
		oms_faults_t flt_s2;
		logic [6:0] tick_cnt;
		logic tick;
		logic [15:0] shift;
		logic [3:0] bit_cnt;
		logic word_done;
		logic word_msb;
		logic last_toggle;
		logic wd_run;
		logic [18:0] wd_cnt;
		logic wd_expired;
		logic fs_armed;
		logic [1:0][18:0] act_cnt;
		logic [1:0] input_activity;
		logic [18:0] ready_cnt;
		logic ready;
		logic [15:0] pwm_div;
		logic [7:0] pwm_cnt;
		oms_mode_t mode;
		logic failsafe_term;
		oms_cfg_t cfg;
		oms_pw_t [1:0] pw;
		logic power_on_flag;
		logic [1:0] target_on;
		logic normal_mode_flag;
		logic fsi_out;
		logic fsi_oe;
		logic fault_delatch;
		logic [15:0] rdata;
	} oms_state_t;

endpackage

// file: verilog/oms_supervisor.sv
// operating-mode supervisor: mode decision, watchdog, input timeouts, channel targets
// assumes pins and the serial link are asynchronous; register port is on clk
`timescale 1ns/10ps
`include "oms_regs.svh"

module oms_supervisor #(
	parameter int TICK_CYC = `OMS_TICK_NS / `OMS_CLK_NS,
	parameter int WD_TICKS = `OMS_WD_TIMEOUT_MS * 1000000 / `OMS_TICK_NS,
	parameter int ACT_TICKS = `OMS_ACT_TIMEOUT_MS * 1000000 / `OMS_TICK_NS,
	parameter int READY_TICKS = `OMS_READY_US * 1000 / `OMS_TICK_NS,
	parameter int PWM_DIV = `OMS_PWM_DIV
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire oms_pkg::oms_link_t link,
	input wire logic wake_control_pin,
	input wire logic [1:0] direct_input,
	input wire logic logic_supply_fail,
	input wire oms_pkg::oms_faults_t faults,
	output oms_pkg::oms_mode_t mode,
	output logic normal_mode_flag,
	output logic [1:0] target_on,
	output logic [1:0] input_activity,
	output logic failsafe_indicator_n_out,
	output logic failsafe_indicator_n_oe,
	output logic fault_delatch
);

	oms_pkg::oms_state_t q;
	oms_pkg::oms_state_t d;
	logic wake;
	logic fault;
	logic fs_cause;
	logic wd_active;
	logic exit_req;
	logic acc_ok;
	logic pwm_act;
	logic [1:0] direct;
	logic [1:0] spi;
	oms_pkg::oms_mode_t nm;
	logic [11:0] stat;

	always_comb begin
		d = q;
		wake = 1'b0;
		fault = 1'b0;
		fs_cause = 1'b0;
		wd_active = 1'b0;
		exit_req = 1'b0;
		acc_ok = 1'b0;
		pwm_act = 1'b0;
		direct = 2'b00;
		spi = 2'b00;
		nm = oms_pkg::OMS_SLEEP;
		stat = 12'h000;

		// input synchronisers
		d.link_s1 = link;
		d.link_s2 = q.link_s1;
		d.wake_s1 = wake_control_pin;
		d.wake_s2 = q.wake_s1;
		d.wake_prev = q.wake_s2;
		d.din_s1 = direct_input;
		d.din_s2 = q.din_s1;
		d.din_prev = q.din_s2;
		d.lsf_s1 = logic_supply_fail;
		d.lsf_s2 = q.lsf_s1;
		d.flt_s1 = faults;
		d.flt_s2 = q.flt_s1;
		d.word_done = 1'b0;
		d.fault_delatch = 1'b0;
		d.rdata = 16'h0000;

		// free-running oscillator tick
		d.tick = 1'b0;
		if (q.tick_cnt == 7'(TICK_CYC - 1)) begin // R23
			d.tick_cnt = 7'h00;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 7'h01;
		end

		// direct input activity
		for (int i = 0; i < 2; i++) begin
			if (q.din_s2[i]) begin
				d.act_cnt[i] = 19'h00000;
				if (!q.din_prev[i]) begin
					d.input_activity[i] = 1'b1; // R9
				end
			end else if (q.input_activity[i] && q.tick) begin
				if (int'(q.act_cnt[i]) >= ACT_TICKS - 1) begin
					d.input_activity[i] = 1'b0; // R13
				end else begin
					d.act_cnt[i] = q.act_cnt[i] + 19'h00001; // R23
				end
			end
		end

		wake = q.wake_s2 | q.input_activity[0] | q.input_activity[1]; // R2
		fault = (|q.flt_s2.overcurrent) | (|q.flt_s2.overtemperature) | (|q.flt_s2.short_circuit) |
			q.flt_s2.undervoltage | (q.flt_s2.overvoltage & q.cfg.overvoltage_fault_select); // R4

		// serial receiver, off in sleep
		d.sclk_prev = q.link_s2.sclk;
		if (q.link_s2.csn || q.mode == oms_pkg::OMS_SLEEP) begin // R14
			d.bit_cnt = 4'h0;
		end else if (q.sclk_prev && !q.link_s2.sclk) begin // R21
			d.shift = {q.shift[14:0], q.link_s2.si};
			d.bit_cnt = q.bit_cnt + 4'h1;
			if (q.bit_cnt == 4'hf) begin
				d.word_done = 1'b1;
				d.word_msb = q.shift[14];
			end
		end

		// watchdog and fail-safe exit window
		wd_active = !q.lsf_s2 && !q.cfg.watchdog_disable && q.wake_s2; // R12
		if (q.failsafe_term) begin
			d.wd_expired = 1'b0;
			d.wd_run = 1'b0;
			if (q.word_done && q.fs_armed) begin
				exit_req = 1'b1; // R19
				d.fs_armed = 1'b0;
			end else if (q.word_done && q.word_msb) begin
				d.fs_armed = 1'b1; // R19
				d.wd_cnt = 19'h00000;
			end else if (q.fs_armed && q.tick) begin
				if (int'(q.wd_cnt) >= WD_TICKS - 1) begin
					d.fs_armed = 1'b0;
				end else begin
					d.wd_cnt = q.wd_cnt + 19'h00001;
				end
			end
		end else if (!wd_active) begin
			d.wd_run = 1'b0;
			d.wd_cnt = 19'h00000;
		end else if (q.wake_s2 && !q.wake_prev) begin
			d.wd_run = 1'b1; // R11
			d.wd_cnt = 19'h00000;
		end else if (q.wd_run) begin
			if (q.word_done && q.word_msb != q.last_toggle) begin
				d.wd_cnt = 19'h00000; // R11
				d.last_toggle = q.word_msb;
			end else if (q.tick) begin
				if (int'(q.wd_cnt) >= WD_TICKS - 1) begin
					d.wd_expired = 1'b1; // R11
					d.wd_run = 1'b0;
				end else begin
					d.wd_cnt = q.wd_cnt + 19'h00001; // R23
				end
			end
		end

		fs_cause = (q.lsf_s2 & q.cfg.logic_supply_fail_enable) |
			(q.wd_expired & !q.cfg.watchdog_disable); // R3
		if (fs_cause) begin
			d.failsafe_term = 1'b1;
		end else if (exit_req && !q.lsf_s2) begin
			d.failsafe_term = 1'b0;
			d.wd_run = wd_active;
			d.wd_cnt = 19'h00000;
			d.last_toggle = q.word_msb;
		end

		// mode priority
		if (!wake) begin
			nm = oms_pkg::OMS_SLEEP; // R5
		end else if (fault) begin
			nm = oms_pkg::OMS_FAULT; // R5
		end else if (q.failsafe_term) begin
			nm = oms_pkg::OMS_FAILSAFE; // R5
		end else begin
			nm = oms_pkg::OMS_NORMAL; // R1
		end
		d.mode = nm;
		d.normal_mode_flag = nm == oms_pkg::OMS_NORMAL; // R1

		// register port
		acc_ok = q.mode != oms_pkg::OMS_SLEEP && !q.failsafe_term; // R18
		stat = {q.target_on, q.cfg.parallel_mode_flag, q.power_on_flag, wake, q.input_activity, fault,
			q.failsafe_term, q.normal_mode_flag, q.mode};
		if (reg_wr && acc_ok) begin
			case (reg_addr)
				`OMS_REG_CFG: begin
					d.cfg = oms_pkg::oms_cfg_t'(reg_wdata[`OMS_CFG_MSB:0]);
				end
				`OMS_REG_PW0: begin
					d.pw[0] = oms_pkg::oms_pw_t'(reg_wdata[`OMS_PW_MSB:0]); // R8
				end
				`OMS_REG_PW1: begin
					d.pw[1] = oms_pkg::oms_pw_t'(reg_wdata[`OMS_PW_MSB:0]); // R8
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`OMS_REG_CFG: begin
					d.rdata = acc_ok ? {8'h00, q.cfg} : 16'h0000;
				end
				`OMS_REG_PW0: begin
					d.rdata = acc_ok ? {7'h00, q.pw[0]} : 16'h0000;
				end
				`OMS_REG_PW1: begin
					d.rdata = acc_ok ? {7'h00, q.pw[1]} : 16'h0000;
				end
				`OMS_REG_STATUS: begin
					d.rdata = {`OMS_STAT_PAD, stat};
					d.power_on_flag = 1'b0;
				end
				default: begin
					d.rdata = 16'h0000;
				end
			endcase
		end

		// register resets on mode events
		if (!q.failsafe_term && d.failsafe_term) begin
			d.cfg = oms_pkg::oms_cfg_t'(`OMS_CFG_RESET); // R18
			d.cfg.parallel_mode_flag = q.cfg.parallel_mode_flag;
			d.pw = {2{oms_pkg::oms_pw_t'(`OMS_PW_RESET)}};
			d.fault_delatch = 1'b1; // R18
			d.fs_armed = 1'b0;
		end else if (q.failsafe_term && !d.failsafe_term) begin
			d.cfg = oms_pkg::oms_cfg_t'(`OMS_CFG_RESET); // R20
			d.cfg.parallel_mode_flag = q.cfg.parallel_mode_flag;
			d.pw = {2{oms_pkg::oms_pw_t'(`OMS_PW_RESET)}};
		end
		if (nm == oms_pkg::OMS_SLEEP) begin
			d.cfg = oms_pkg::oms_cfg_t'(`OMS_CFG_RESET); // R14
			d.pw = {2{oms_pkg::oms_pw_t'(`OMS_PW_RESET)}};
			d.failsafe_term = 1'b0;
			d.fs_armed = 1'b0;
			d.wd_expired = 1'b0;
			d.ready = 1'b0;
			d.ready_cnt = 19'h00000;
		end else if (q.mode == oms_pkg::OMS_SLEEP) begin
			d.cfg = oms_pkg::oms_cfg_t'(`OMS_CFG_RESET); // R22
			d.pw = {2{oms_pkg::oms_pw_t'(`OMS_PW_RESET)}};
		end else if (!q.ready && q.tick) begin
			if (int'(q.ready_cnt) >= READY_TICKS - 1) begin
				d.ready = 1'b1; // R22
			end else begin
				d.ready_cnt = q.ready_cnt + 19'h00001;
			end
		end

		// pwm phase
		if (q.pwm_div == 16'(PWM_DIV - 1)) begin
			d.pwm_div = 16'h0000;
			d.pwm_cnt = q.pwm_cnt + 8'h01;
		end else begin
			d.pwm_div = q.pwm_div + 16'h0001;
		end

		// channel targets
		for (int i = 0; i < 2; i++) begin
			pwm_act = q.pwm_cnt <= q.pw[i].duty; // R8
			direct[i] = q.din_s2[i] & !q.cfg.direct_input_disable[i]; // R6
			spi[i] = q.pw[i].channel_on_bit & (!q.cfg.pwm_enable[i] | pwm_act);
			if (!q.ready || nm == oms_pkg::OMS_SLEEP || nm == oms_pkg::OMS_FAULT) begin
				d.target_on[i] = 1'b0; // R5
			end else if (nm == oms_pkg::OMS_FAILSAFE || !q.wake_s2) begin
				d.target_on[i] = q.din_s2[i]; // R16
			end else begin
				d.target_on[i] = direct[i] | spi[i]; // R7
			end
		end

		// indicator follows the registered term, in step with mode
		d.fsi_oe = q.failsafe_term; // R18
		d.fsi_out = !q.failsafe_term; // R20
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0; // R15
			q.cfg <= `OMS_CFG_RESET;
			q.power_on_flag <= 1'b1;
			q.fsi_out <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign mode = q.mode;
	assign normal_mode_flag = q.normal_mode_flag;
	assign target_on = q.target_on;
	assign input_activity = q.input_activity;
	assign failsafe_indicator_n_out = q.fsi_out;
	assign failsafe_indicator_n_oe = q.fsi_oe;
	assign fault_delatch = q.fault_delatch;

endmodule

// file: tb/oms_chk.sv
// checker: mode, target and indicator relations at the supervisor ports
// assumes bind onto oms_supervisor; tick defaults match the bench
`timescale 1ns/10ps
module oms_chk #(
	parameter int TICK_CYC = 2,
	parameter int ACT_TICKS = 30
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire oms_pkg::oms_link_t link,
	input wire logic wake_control_pin,
	input wire logic [1:0] direct_input,
	input wire logic logic_supply_fail,
	input wire oms_pkg::oms_faults_t faults,
	input wire oms_pkg::oms_mode_t mode,
	input wire logic normal_mode_flag,
	input wire logic [1:0] target_on,
	input wire logic [1:0] input_activity,
	input wire logic failsafe_indicator_n_out,
	input wire logic failsafe_indicator_n_oe,
	input wire logic fault_delatch
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// low time of channel 0 input, saturating
	logic [19:0] low_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_q <= 20'h00000;
		end else begin
			low_q <= direct_input[0] ? 20'h00000 : low_q + {19'h00000, ~&low_q};
		end
	end
	AST_NM: assert property (normal_mode_flag == (mode == oms_pkg::OMS_NORMAL)) else $error("flag off mode");
	AST_SLEEP_OFF: assert property ((mode == oms_pkg::OMS_SLEEP) [*2] |-> target_on == 2'b00)
		else $error("target in sleep");
	AST_FAULT_OFF: assert property ((mode == oms_pkg::OMS_FAULT) [*2] |-> target_on == 2'b00)
		else $error("target in fault");
	AST_FS_PIN: assert property ((mode == oms_pkg::OMS_FAILSAFE) [*2] |->
		!failsafe_indicator_n_out && failsafe_indicator_n_oe) else $error("indicator not low");
	AST_DELATCH: assert property (fault_delatch |=> !fault_delatch && failsafe_indicator_n_oe)
		else $error("delatch pulse bad");
	AST_FS_DIN: assert property ((mode == oms_pkg::OMS_FAILSAFE && $stable(direct_input)) [*6] |->
		target_on == direct_input) else $error("target not direct");
	AST_SLEEP: assert property ((input_activity == 2'b00 && !wake_control_pin) [*8] |->
		mode == oms_pkg::OMS_SLEEP) else $error("awake without wake");
	AST_ACT_LOW: assert property (low_q > ACT_TICKS * TICK_CYC + TICK_CYC + 6 |-> !input_activity[0])
		else $error("activity kept");
	cover property (mode == oms_pkg::OMS_FAILSAFE);
	cover property (mode == oms_pkg::OMS_FAULT);
	cover property (fault_delatch);
endmodule

bind oms_supervisor oms_chk oms_chk_i (.clk(clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.link(link), .wake_control_pin(wake_control_pin), .direct_input(direct_input),
	.logic_supply_fail(logic_supply_fail), .faults(faults), .mode(mode), .normal_mode_flag(normal_mode_flag),
	.target_on(target_on), .input_activity(input_activity), .failsafe_indicator_n_out(failsafe_indicator_n_out),
	.failsafe_indicator_n_oe(failsafe_indicator_n_oe), .fault_delatch(fault_delatch));

// file: tb/oms_host.sv
// host model: sends serial words on the link, 160 ns bit clock
// assumes sclk and si rest low through their pull-downs
`timescale 1ns/10ps
module oms_host (
	input wire logic clk,
	output oms_pkg::oms_link_t link
);
	initial link = '{sclk: 1'b0, csn: 1'b1, si: 1'b0};
	task automatic send_word(input logic [15:0] w);
		@(posedge clk);
		#37;
		link.csn = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			link.si = w[i];
			#40;
			link.sclk = 1'b1;
			#80;
			link.sclk = 1'b0;
			#40;
		end
		link.csn = 1'b1;
		link.si = 1'b0;
	endtask
endmodule

// file: tb/oms_supervisor_tb.sv
// bench: register, wake, direct-input, serial and fault scenarios
// assumes oms_host on the link and shortened tick parameters
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module oms_supervisor_tb;
	localparam int TICK = 2;
	localparam int ACT = 30;
	logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, wake = 1'b0, lsf = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata, d;
	logic [1:0] din = 2'b00, tgt, act;
	logic [7:0] duty [3] = '{8'h00, 8'h0f, 8'hff};
	oms_pkg::oms_faults_t faults = '0;
	oms_pkg::oms_link_t link;
	oms_pkg::oms_mode_t mode;
	logic nm, fs_out, fs_oe, dl;
	int num_errors = 0, check_count = 0, n, dl_n = 0;
	wire fs_pin = fs_oe ? fs_out : 1'b1;
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		if (dl === 1'b1) begin
			dl_n++;
		end
	end
	oms_host oms_host_i (.clk(clk), .link(link));
	oms_supervisor #(.TICK_CYC(TICK), .WD_TICKS(400), .ACT_TICKS(ACT))
	oms_supervisor_i (.clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata), .link(link), .wake_control_pin(wake), .direct_input(din),
		.logic_supply_fail(lsf), .faults(faults), .mode(mode), .normal_mode_flag(nm), .target_on(tgt),
		.input_activity(act), .failsafe_indicator_n_out(fs_out), .failsafe_indicator_n_oe(fs_oe),
		.fault_delatch(dl));
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic wmode(input oms_pkg::oms_mode_t m);
		for (int i = 0; i < 3000 && mode !== m; i++) @(posedge clk);
		cyc(2);
		`CHK("mode", m, mode)
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		finish_test;
	end
	initial begin
		cyc(5);
		reset_n <= 1'b1;
		cyc(2);
		`CHK("mode", oms_pkg::OMS_SLEEP, mode)
		`CHK("pin", 1'b1, fs_pin)
		rd(4'h3);
		`CHK("status", 16'h0100, d)
		rd(4'h3);
		`CHK("status", 16'h0000, d)
		rd(4'hf);
		`CHK("unmapped", 16'h0000, d)
		din[1] <= 1'b1;
		wmode(oms_pkg::OMS_NORMAL);
		cyc(120);
		`CHK("target", 2'b10, tgt)
		din[1] <= 1'b0;
		cyc(ACT * TICK - 16);
		`CHK("activity", 2'b10, act)
		wmode(oms_pkg::OMS_SLEEP);
		`CHK("activity", 2'b00, act)
		wr(4'h0, 16'h00ff);
		wake <= 1'b1;
		wmode(oms_pkg::OMS_NORMAL);
		`CHK("flag", 1'b1, nm)
		rd(4'h0);
		`CHK("cfg", 16'h0004, d)
		oms_host_i.send_word(16'h8000);
		oms_host_i.send_word(16'h0000);
		oms_host_i.send_word(16'h8000);
		`CHK("mode", oms_pkg::OMS_NORMAL, mode)
		wmode(oms_pkg::OMS_FAILSAFE);
		`CHK("pin", 1'b0, fs_pin)
		`CHK("delatch", 1, dl_n)
		rd(4'h0);
		`CHK("cfg", 16'h0000, d)
		din[0] <= 1'b1;
		cyc(8);
		`CHK("target", 2'b01, tgt)
		din[0] <= 1'b0;
		oms_host_i.send_word(16'h8000);
		oms_host_i.send_word(16'h0000);
		wmode(oms_pkg::OMS_NORMAL);
		`CHK("pin", 1'b1, fs_pin)
		rd(4'h0);
		`CHK("cfg", 16'h0004, d)
		wr(4'h0, 16'h0005);
		wr(4'h1, 16'h0100);
		cyc(6);
		`CHK("target", 2'b01, tgt)
		wr(4'h0, 16'h0025);
		wr(4'h1, 16'h0000);
		din[0] <= 1'b1;
		cyc(8);
		`CHK("target", 2'b00, tgt)
		wr(4'h0, 16'h0005);
		cyc(6);
		`CHK("target", 2'b01, tgt)
		din[0] <= 1'b0;
		wr(4'h0, 16'h000d);
		foreach (duty[i]) begin
			wr(4'h1, {8'h01, duty[i]});
			cyc(6);
			n = 0;
			repeat (256) begin
				n += tgt[0];
				cyc(16);
			end
			`CHK("highs", {1'b0, duty[i]} + 9'h001, n[8:0])
		end
		wr(4'h0, 16'h0005);
		wr(4'h1, 16'h0100);
		for (int i = 0; i < 8; i++) begin
			faults <= 8'h01 << i;
			wmode(oms_pkg::OMS_FAULT);
			`CHK("target", 2'b00, tgt)
			faults <= '0;
			wmode(oms_pkg::OMS_NORMAL);
		end
		wr(4'h0, 16'h0001);
		faults <= 8'h01;
		cyc(12);
		`CHK("mode", oms_pkg::OMS_NORMAL, mode)
		faults <= '0;
		wr(4'h0, 16'h0007);
		lsf <= 1'b1;
		wmode(oms_pkg::OMS_FAILSAFE);
		`CHK("pin", 1'b0, fs_pin)
		`CHK("delatch", 2, dl_n)
		wake <= 1'b0;
		lsf <= 1'b0;
		reset_n <= 1'b0;
		cyc(3);
		reset_n <= 1'b1;
		cyc(2);
		`CHK("mode", oms_pkg::OMS_SLEEP, mode)
		finish_test;
	end
endmodule
